// *** hw/nwtd_pkg.sv ***
package nwtd_pkg;

    // ------------------------------------------------------------
    // status pattern
    // ------------------------------------------------------------
    localparam logic [4:0] ST_RESET = 5'h1d;
    localparam int ST_MAIN_N = 4;
    localparam int ST_WIN_N = 3;
    localparam int ST_FLAG_N = 2;
    localparam int ST_POST = 1;
    localparam int ST_RATE = 0;

    // ------------------------------------------------------------
    // raw readback words
    // ------------------------------------------------------------
    localparam int TC_RATE = 1;
    localparam int TC_POST = 2;
    localparam int IO_MAIN = 4;
    localparam int IO_WIN = 5;
    localparam int IO_FLAG = 6;

    // ------------------------------------------------------------
    // counter and delay line
    // ------------------------------------------------------------
    localparam int POST_PRELOAD = 1;
    localparam int DELAY_STAGES = 6;

    // ------------------------------------------------------------
    // processor-side register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CMD = 4'h4;
    localparam logic [3:0] OFS_EXPECT = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    localparam int CTL_RESET_N = 0;
    localparam int CTL_MAIN_SET = 1;
    localparam int CTL_WIN_SET = 2;
    localparam int CTL_FLIP = 3;
    localparam int CTL_REARM_SET = 4;
    localparam int CTL_REARM_CLR_N = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int CMD_STEP = 0;
    localparam int CMD_CHECK = 1;
    localparam logic [7:0] EXPECT_RESET = 8'h00;
    localparam logic [15:0] ERR_BASE = 16'h2360;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {STEP_IDLE, STEP_HIGH, STEP_LOW} nwtd_step_t;

endpackage : nwtd_pkg

// *** hw/nwtd_if.sv ***
`timescale 1ns/1ps
interface nwtd_if;
    logic sys_clk;
    logic sys_reset_n;
    logic main_gate_set;
    logic window_gate_set;
    logic flip_control;
    logic rearm_set;
    logic rearm_clear_n;
    logic [7:0] tc_word;
    logic [7:0] io_word;
    logic variant;
    logic rearm_n;
    logic delayed_count_n;
    logic delayed_decision_n;
    logic late_window_n;

    modport dev (
        input sys_reset_n, main_gate_set, window_gate_set, flip_control,
        input rearm_set, rearm_clear_n,
        output tc_word, io_word, variant, rearm_n,
        output delayed_count_n, delayed_decision_n, late_window_n
    );
    modport host (
        output sys_clk, sys_reset_n, main_gate_set, window_gate_set, flip_control,
        output rearm_set, rearm_clear_n,
        input tc_word, io_word, variant, rearm_n,
        input delayed_count_n, delayed_decision_n, late_window_n
    );
endinterface : nwtd_if

// *** hw/nwtd_post_counter.sv ***
`timescale 1ns/1ps
module nwtd_post_counter #(
    parameter int WIDTH = 16,
    parameter int PRELOAD = 1
) (
    // clock and load
    input wire logic i_clock,
    input wire logic i_load,
    // count enable
    input wire logic i_count,
    // terminal count
    output logic o_done,
    output logic o_done_next
);
    // ------------------------------------------------------------
    // down counter
    // ------------------------------------------------------------
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic done_reg;
    logic done_next;

    always_comb begin
        count_next = count_reg;
        done_next = done_reg;
        if (i_load) begin
            count_next = WIDTH'(PRELOAD);
            done_next = 1'b0;
        end else if (i_count) begin
            // terminal count trails the zero by one edge
            done_next = (count_reg == '0);
            if (count_reg != '0) begin
                count_next = count_reg - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        count_reg <= count_next;
        done_reg <= done_next;
    end

    assign o_done = done_reg;
    assign o_done_next = done_next;
endmodule : nwtd_post_counter

// *** hw/nwtd_device.sv ***
`timescale 1ns/1ps
module nwtd_device
    import nwtd_pkg::*;
#(
    parameter int POST_WIDTH = 16,
    parameter int DELAY_LEN = DELAY_STAGES
) (
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // processor side
    nwtd_if.dev LINK,
    // acquisition side
    input wire logic I_WINDOW_ACQ_TRIGGER,
    input wire logic I_VARIANT,
    // gates and flag
    output logic O_MAIN_GATE,
    output logic O_WINDOW_GATE,
    output logic O_WINDOW_GATE_N,
    output logic O_NO_WINDOW_FLAG,
    output logic O_NO_WINDOW_FLAG_N,
    output logic O_WINDOW_TRIGGER_OUT
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] acq_sync_reg;
    logic [2:0] acq_sync_next;
    logic acq_level_reg;
    logic acq_level_next;
    logic [2:0] var_sync_reg;
    logic [2:0] var_sync_next;
    logic variant_reg;
    logic variant_next;

    always_comb begin
        acq_sync_next = {acq_sync_reg[1:0], I_WINDOW_ACQ_TRIGGER};
        var_sync_next = {var_sync_reg[1:0], I_VARIANT};
        acq_level_next = acq_level_reg;
        variant_next = variant_reg;
        if (acq_sync_reg[1] == acq_sync_reg[2]) begin
            acq_level_next = acq_sync_reg[2];
        end
        // strap is taken only while the chip reset is held
        if (I_RST && (var_sync_reg[1] == var_sync_reg[2])) begin
            variant_next = var_sync_reg[2];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            acq_sync_reg <= 3'h0;
            acq_level_reg <= 1'b0;
            var_sync_reg <= var_sync_next;
            variant_reg <= variant_next;
        end else begin
            acq_sync_reg <= acq_sync_next;
            acq_level_reg <= acq_level_next;
            var_sync_reg <= var_sync_next;
            variant_reg <= variant_next;
        end
    end

    // ------------------------------------------------------------
    // post-record counter
    // ------------------------------------------------------------
    logic rst_all;
    logic main_reg;
    logic post_done;
    logic post_done_next;

    assign rst_all = I_RST | ~LINK.sys_reset_n;

    nwtd_post_counter #(
        .WIDTH(POST_WIDTH),
        .PRELOAD(POST_PRELOAD)
    ) u_post (
        .i_clock(I_CLOCK),
        .i_load(rst_all),
        .i_count(main_reg),
        .o_done(post_done),
        .o_done_next(post_done_next)
    );

    // ------------------------------------------------------------
    // gates, decision and readback
    // ------------------------------------------------------------
    logic win_reg, win_next;
    logic main_next;
    logic flag_reg, flag_next;
    logic early_reg, early_next;
    logic flip_reg, flip_next;
    logic rate_next;
    logic rearm_n_reg, rearm_n_next;
    logic late_n_reg, late_n_next;
    logic trig_reg, trig_next;
    logic [DELAY_LEN-1:0] dly_reg, dly_next;
    logic [7:0] tc_reg, tc_next;
    logic [7:0] io_reg, io_next;
    logic decision;
    logic win_n_reg, flag_n_reg;

    // flip high picks the later tap, buying one more edge of window
    assign decision = variant_reg
        ? (flip_reg ? dly_reg[DELAY_LEN-1] : dly_reg[DELAY_LEN-2])
        : post_done;

    always_comb begin
        main_next = main_reg | LINK.main_gate_set;
        win_next = win_reg | LINK.window_gate_set | flag_reg;
        // window seen while the decision is still low disarms the flag
        early_next = early_reg | (win_reg & ~decision);
        // window on the very edge of done is still too late
        flag_next = flag_reg | (main_reg & decision & ~early_reg);
        flip_next = flip_reg;
        if (LINK.flip_control) begin
            flip_next = 1'b1;
        end else if (variant_reg && decision) begin
            flip_next = 1'b0;
        end
        dly_next = {dly_reg[DELAY_LEN-2:0], post_done};
        late_n_next = late_n_reg;
        if (variant_reg && decision && win_next && !win_reg) begin
            late_n_next = 1'b0;
        end
        rate_next = 1'b1;
        rearm_n_next = rearm_n_reg;
        if (LINK.rearm_set) begin
            rearm_n_next = 1'b1;
        end else if (!LINK.rearm_clear_n) begin
            rearm_n_next = 1'b0;
        end
        trig_next = acq_level_reg | LINK.window_gate_set;
        // words follow next state so reads between steps are settled
        tc_next = 8'h00;
        tc_next[TC_POST] = post_done_next;
        tc_next[TC_RATE] = rate_next;
        io_next = 8'h00;
        io_next[IO_MAIN] = main_next;
        io_next[IO_WIN] = win_next;
        io_next[IO_FLAG] = flag_next;
        if (rst_all) begin
            main_next = 1'b0;
            win_next = 1'b0;
            early_next = 1'b0;
            flag_next = 1'b0;
            flip_next = 1'b0;
            dly_next = '0;
            late_n_next = 1'b1;
            rearm_n_next = 1'b0;
            trig_next = 1'b0;
            tc_next = 8'h00;
            tc_next[TC_RATE] = 1'b1;
            io_next = 8'h00;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        main_reg <= main_next;
        win_reg <= win_next;
        early_reg <= early_next;
        flag_reg <= flag_next;
        flip_reg <= flip_next;
        dly_reg <= dly_next;
        late_n_reg <= late_n_next;
        win_n_reg <= ~win_next;
        flag_n_reg <= ~flag_next;
        rearm_n_reg <= rearm_n_next;
        trig_reg <= trig_next;
        tc_reg <= tc_next;
        io_reg <= io_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_MAIN_GATE = main_reg;
    assign O_WINDOW_GATE = win_reg;
    assign O_WINDOW_GATE_N = win_n_reg;
    assign O_NO_WINDOW_FLAG = flag_reg;
    assign O_NO_WINDOW_FLAG_N = flag_n_reg;
    assign O_WINDOW_TRIGGER_OUT = trig_reg;
    assign LINK.tc_word = tc_reg;
    assign LINK.io_word = io_reg;
    assign LINK.variant = variant_reg;
    assign LINK.rearm_n = rearm_n_reg;
    assign LINK.delayed_count_n = ~dly_reg[0];
    assign LINK.delayed_decision_n = ~(variant_reg & decision);
    assign LINK.late_window_n = late_n_reg;
endmodule : nwtd_device

// *** hw/nwtd_host.sv ***
`timescale 1ns/1ps
module nwtd_host
    import nwtd_pkg::*;
(
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // device side
    nwtd_if.host LINK,
    // axi4-lite write
    input wire logic I_AWVALID,
    input wire logic [3:0] I_AWADDR,
    output logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_WREADY,
    output logic O_BVALID,
    output logic [1:0] O_BRESP,
    input wire logic I_BREADY,
    // axi4-lite read
    input wire logic I_ARVALID,
    input wire logic [3:0] I_ARADDR,
    output logic O_ARREADY,
    output logic O_RVALID,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    input wire logic I_RREADY
);
    // ------------------------------------------------------------
    // bus slave and step engine
    // ------------------------------------------------------------
    logic awr_reg, awr_next, ar_reg, ar_next;
    logic bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [5:0] ctrl_reg, ctrl_next;
    logic [7:0] exp_reg, exp_next;
    logic [4:0] pat_reg, pat_next;
    logic [15:0] err_reg, err_next;
    nwtd_step_t step_reg, step_next;
    logic [7:0] inv;
    logic [4:0] pat;
    logic wr, rd;

    assign wr = awr_reg & I_AWVALID & I_WVALID;
    assign rd = ar_reg & I_ARVALID;
    assign inv = ~LINK.io_word;
    assign pat = {inv[IO_MAIN], inv[IO_WIN], inv[IO_FLAG],
        LINK.tc_word[TC_POST], LINK.tc_word[TC_RATE]};

    always_comb begin
        awr_next = I_AWVALID & I_WVALID & ~awr_reg & ~bv_reg;
        ar_next = I_ARVALID & ~ar_reg & ~rv_reg;
        bv_next = bv_reg & ~I_BREADY;
        rv_next = rv_reg & ~I_RREADY;
        bresp_next = bresp_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        exp_next = exp_reg;
        pat_next = pat_reg;
        err_next = err_reg;
        step_next = step_reg;
        unique case (step_reg)
            STEP_IDLE: step_next = STEP_IDLE;
            STEP_HIGH: step_next = STEP_LOW;
            STEP_LOW: step_next = STEP_IDLE;
        endcase
        if (wr) begin
            bv_next = 1'b1;
            bresp_next = RESP_OKAY;
            unique case (I_AWADDR)
                OFS_CTRL: if (I_WSTRB[0]) ctrl_next = I_WDATA[5:0];
                OFS_EXPECT: if (I_WSTRB[0]) exp_next = I_WDATA[7:0];
                OFS_CMD: begin
                    // a step request while stepping is dropped
                    if (I_WSTRB[0] && I_WDATA[CMD_STEP] && step_reg == STEP_IDLE) begin
                        step_next = STEP_HIGH;
                    end
                    if (I_WSTRB[0] && I_WDATA[CMD_CHECK]) begin
                        pat_next = pat;
                        if (pat != exp_reg[4:0]) begin
                            err_next = ERR_BASE + {13'h0000, exp_reg[7:5]};
                        end
                    end
                end
                OFS_STATUS: err_next = 16'h0000;
                default: bresp_next = RESP_SLVERR;
            endcase
        end
        if (rd) begin
            rv_next = 1'b1;
            rresp_next = RESP_OKAY;
            unique case (I_ARADDR)
                OFS_CTRL: rdata_next = {26'h0000000, ctrl_reg};
                OFS_EXPECT: rdata_next = {24'h000000, exp_reg};
                OFS_CMD: rdata_next = 32'h00000000;
                OFS_STATUS: rdata_next = {err_reg, 8'h00, LINK.rearm_n,
                    LINK.variant, step_reg != STEP_IDLE, pat_reg};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
        if (I_RST) begin
            awr_next = 1'b0;
            ar_next = 1'b0;
            bv_next = 1'b0;
            rv_next = 1'b0;
            bresp_next = RESP_OKAY;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h00000000;
            ctrl_next = CTRL_RESET;
            exp_next = EXPECT_RESET;
            pat_next = ST_RESET;
            err_next = 16'h0000;
            step_next = STEP_IDLE;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        awr_reg <= awr_next;
        ar_reg <= ar_next;
        bv_reg <= bv_next;
        rv_reg <= rv_next;
        bresp_reg <= bresp_next;
        rresp_reg <= rresp_next;
        rdata_reg <= rdata_next;
        ctrl_reg <= ctrl_next;
        exp_reg <= exp_next;
        pat_reg <= pat_next;
        err_reg <= err_next;
        step_reg <= step_next;
    end

    assign O_AWREADY = awr_reg;
    assign O_WREADY = awr_reg;
    assign O_BVALID = bv_reg;
    assign O_BRESP = bresp_reg;
    assign O_ARREADY = ar_reg;
    assign O_RVALID = rv_reg;
    assign O_RDATA = rdata_reg;
    assign O_RRESP = rresp_reg;
    assign LINK.sys_clk = (step_reg == STEP_HIGH);
    assign LINK.sys_reset_n = ctrl_reg[CTL_RESET_N];
    assign LINK.main_gate_set = ctrl_reg[CTL_MAIN_SET];
    assign LINK.window_gate_set = ctrl_reg[CTL_WIN_SET];
    assign LINK.flip_control = ctrl_reg[CTL_FLIP];
    assign LINK.rearm_set = ctrl_reg[CTL_REARM_SET];
    assign LINK.rearm_clear_n = ctrl_reg[CTL_REARM_CLR_N];
endmodule : nwtd_host

// *** tb/nwtd_chk.sv ***
`timescale 1ns/1ps
module nwtd_chk (
    // device clock and reset
    input wire logic sys_clk,
    input wire logic sys_reset_n,
    // controls
    input wire logic main_gate_set,
    input wire logic window_gate_set,
    input wire logic rearm_set,
    // readback
    input wire logic [7:0] tc_word,
    input wire logic [7:0] io_word,
    input wire logic variant,
    input wire logic rearm_n,
    input wire logic delayed_count_n,
    input wire logic delayed_decision_n,
    input wire logic late_window_n
);
    // ------------------------------------------------------------
    // checks on the stepped device clock
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!sys_reset_n);

    chk_main_gate_set: assert property (main_gate_set |=> io_word[4])
        else $error("main gate did not follow its set control");
    chk_win_gate_set: assert property (window_gate_set |=> io_word[5])
        else $error("window gate did not follow its set control");
    chk_post_done_time: assert property (
        $rose(io_word[4]) |-> !tc_word[2] ##1 !tc_word[2] ##1 tc_word[2])
        else $error("post record done not two edges after main gate");
    chk_flag_after_done: assert property (
        !variant && $rose(tc_word[2]) && !$past(io_word[5]) |=> io_word[6])
        else $error("flag missing one edge after post record done");
    chk_no_flag_early: assert property (
        io_word[5] && !io_word[6] && (variant ? delayed_decision_n : !tc_word[2])
        |=> !io_word[6] [*4])
        else $error("flag raised although window came in time");
    chk_flag_cause: assert property (
        $rose(io_word[6]) |-> (variant ? !$past(delayed_decision_n) : $past(tc_word[2])))
        else $error("flag raised without a decision before it");
    chk_flag_hold: assert property (io_word[6] |=> io_word[6] && io_word[5])
        else $error("flag or window gate not held after flag");
    chk_word_unused: assert property (
        tc_word[7:3] == 5'h00 && !tc_word[0] && io_word[3:0] == 4'h0 && !io_word[7])
        else $error("unused readback bits not zero");
    chk_reset_idle: assert property (
        $rose(sys_reset_n) |-> io_word[6:4] == 3'h0 && tc_word[2:1] == 2'b01
        && (!variant || (delayed_count_n && delayed_decision_n && late_window_n)))
        else $error("idle state after reset wrong");
    chk_rearm_set: assert property (rearm_set |=> rearm_n)
        else $error("restart line not released by its set control");
    chk_late_window: assert property (
        $rose(io_word[5]) && !$past(delayed_decision_n) |-> !late_window_n)
        else $error("late window gate not marked after decision");
endmodule : nwtd_chk

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top import nwtd_pkg::*; ;
    logic clk, rst, dev_rst, acq, var_sel;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic main_gate, win_gate, win_gate_n, flag, flag_n, trig_out;
    logic [5:0] ctrl;
    logic [15:0] op;
    logic [2:0] scen;
    int n_errors, checks_done, cycles;
    // ------------------------------------------------------------
    // scenario table: header 8xyz, op {steps, window_gate_set, main_gate_set, skip, pattern}
    // ------------------------------------------------------------
    localparam int N_OPS = 54;
    localparam logic [15:0] OPS [N_OPS] = '{
        16'h8001, 16'h140d, 16'h200f, 16'h100b, 16'h1003, 16'h1003, 16'h1003,
        16'h8002, 16'h140d, 16'h1805, 16'h1007, 16'h1007, 16'h1007,
        16'h8003, 16'h1815, 16'h1405, 16'h2007, 16'h1007, 16'h1007,
        16'h8004, 16'h1c05, 16'h2007, 16'h1007, 16'h1007,
        16'h8005, 16'h140d, 16'h1020, 16'h1807, 16'h1003, 16'h1003,
        16'h8301, 16'h140d, 16'h200f, 16'h600f, 16'h100b, 16'h1803, 16'h1003, 16'h1003,
        16'h8302, 16'h140d, 16'h200f, 16'h4020, 16'h1807, 16'h1007, 16'h1007, 16'h1007,
        16'h8303, 16'h140d, 16'h200f, 16'h500f, 16'h1807, 16'h1003, 16'h1003, 16'h1003
    };

    nwtd_if lnk ();
    nwtd_host i_nwtd_host (.I_CLOCK(clk), .I_RST(rst), .LINK(lnk),
        .I_AWVALID(awvalid), .I_AWADDR(awaddr), .O_AWREADY(awready), .I_WVALID(wvalid),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .O_WREADY(wready), .O_BVALID(bvalid),
        .O_BRESP(bresp), .I_BREADY(bready), .I_ARVALID(arvalid), .I_ARADDR(araddr),
        .O_ARREADY(arready), .O_RVALID(rvalid), .O_RDATA(rdata), .O_RRESP(rresp),
        .I_RREADY(rready));
    nwtd_device i_nwtd_device (.I_CLOCK(lnk.sys_clk), .I_RST(dev_rst), .LINK(lnk),
        .I_WINDOW_ACQ_TRIGGER(acq), .I_VARIANT(var_sel), .O_MAIN_GATE(main_gate),
        .O_WINDOW_GATE(win_gate), .O_WINDOW_GATE_N(win_gate_n), .O_NO_WINDOW_FLAG(flag),
        .O_NO_WINDOW_FLAG_N(flag_n), .O_WINDOW_TRIGGER_OUT(trig_out));
    nwtd_chk i_nwtd_chk (.sys_clk(lnk.sys_clk), .sys_reset_n(lnk.sys_reset_n),
        .main_gate_set(lnk.main_gate_set), .window_gate_set(lnk.window_gate_set),
        .rearm_set(lnk.rearm_set), .tc_word(lnk.tc_word), .io_word(lnk.io_word),
        .variant(lnk.variant), .rearm_n(lnk.rearm_n), .delayed_count_n(lnk.delayed_count_n),
        .delayed_decision_n(lnk.delayed_decision_n), .late_window_n(lnk.late_window_n));

    // ------------------------------------------------------------
    // bus cycles and compares
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check("write response", 32'(r), 32'(RESP_OKAY));
    endtask : wr

    // one step is one high and one low cycle of the device clock
    task automatic step(input int n);
        repeat (n) begin
            wr(OFS_CMD, 32'h1 << CMD_STEP);
            repeat (3) @(posedge clk);
        end
    endtask : step

    task automatic set_ctrl(input logic [5:0] c);
        ctrl = c;
        wr(OFS_CTRL, {26'h0, c});
    endtask : set_ctrl

    task automatic init(input logic v, input logic f);
        dev_rst <= 1'b1;
        var_sel <= v;
        set_ctrl(6'h00);
        // the strap needs four edges to pass its synchroniser
        step(4);
        dev_rst <= 1'b0;
        if (f) begin
            set_ctrl(6'h09);
            step(1);
        end
        set_ctrl(6'h11);
    endtask : init

    task automatic pat(input logic [2:0] s, input logic [4:0] e);
        wr(OFS_EXPECT, {24'h0, s, e});
        wr(OFS_CMD, 32'h1 << CMD_CHECK);
        axi_rd(OFS_STATUS, rd, rs);
        check("pattern", 32'(rd[4:0]), 32'(e));
        check("error code", 32'(rd[31:16]), 32'h0);
        check("variant", 32'(rd[6]), 32'(var_sel));
        check("step busy", 32'(rd[5]), 32'h0);
        check("main gate", 32'({main_gate}), 32'({~e[ST_MAIN_N]}));
        check("window gate", 32'({win_gate, win_gate_n}), 32'({~e[3], e[3]}));
        check("flag", 32'({flag, flag_n}), 32'({~e[ST_FLAG_N], e[ST_FLAG_N]}));
    endtask : pat

    task automatic give_verdict();
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // tests take under two thousand cycles; a hung handshake ends here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        rst = 1'b1;
        dev_rst = 1'b1;
        acq = 1'b0;
        var_sel = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wstrb = 4'h0;
        wdata = 32'h0;
        ctrl = 6'h00;
        scen = 3'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < N_OPS; i++) begin
            op = OPS[i];
            if (op[15]) begin
                scen = op[2:0];
                init(op[8], op[9]);
                pat(scen, ST_RESET);
            end else begin
                if (op[11:10] != 2'b00) set_ctrl(ctrl | {3'h0, op[11], op[10], 1'b0});
                step(int'(op[14:12]));
                if (!op[5]) pat(scen, op[4:0]);
            end
        end
        init(1'b0, 1'b0);
        acq <= 1'b1;
        step(5);
        check("trigger out", 32'(trig_out), 32'h1);
        acq <= 1'b0;
        step(5);
        check("trigger out", 32'(trig_out), 32'h0);
        wr(OFS_EXPECT, {24'h0, 3'h5, 5'h00});
        wr(OFS_CMD, 32'h1 << CMD_CHECK);
        axi_rd(OFS_STATUS, rd, rs);
        check("error code", 32'(rd[31:16]), 32'h2365);
        wr(OFS_STATUS, 32'h0);
        axi_rd(OFS_STATUS, rd, rs);
        check("error code", 32'(rd[31:16]), 32'h0);
        axi_rd(4'h2, rd, rs);
        check("unmapped read", {rd[29:0], rs}, 32'(RESP_SLVERR));
        axi_wr(4'h6, 32'h0, rs);
        check("unmapped write", 32'(rs), 32'(RESP_SLVERR));
        give_verdict();
    end
endmodule : tb_top
